// [inc/swd_consts.svh]
`ifndef SWD_CONSTS_SVH
`define SWD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------------------
`define SWD_CLK_MHZ 20
`define SWD_T_MIN_US 2000
`define SWD_T_VCC_MS 1600
`define SWD_US_PER_MS 1000
`define SWD_PF_PER_MS 10
`define SWD_DEF_CAP_PF 1000
`define SWD_T_RESET_HOLD_US 250
`define SWD_INIT_MULT_GND 32'h0000_0001
`define SWD_INIT_MULT_OPEN 32'h0000_0008
`define SWD_INIT_MULT_VCC 32'h0000_0040

// ----------------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------------
`define SWD_ADDR_W 8
`define SWD_OFS_CTRL 8'h00
`define SWD_OFS_STATUS 8'h04
`define SWD_OFS_COUNT 8'h08
`define SWD_OFS_LIMIT 8'h0c
`define SWD_CTRL_EN_BIT 0
`define SWD_CTRL_RESET 1'b1
`define SWD_ST_FAULT_N_BIT 0
`define SWD_ST_RESET_N_BIT 1
`define SWD_ST_INITIAL_BIT 2
`define SWD_ST_CAP_LSB 4
`define SWD_ST_SEL_LSB 6

`endif

// [inc/swd_pkg.sv]
package swd_pkg;

  // Decoded three-state strap: tied low, floating, tied to supply.
  typedef enum logic [1:0] {
    SWD_STRAP_GND,
    SWD_STRAP_OPEN,
    SWD_STRAP_VCC
  } swd_strap_type;

  // Watchdog phase: held in reset, initial window, normal window.
  typedef enum logic [1:0] {
    SWD_PH_HOLD,
    SWD_PH_INITIAL,
    SWD_PH_NORMAL
  } swd_phase_type;

  // One APB request as seen by the slave.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } swd_apb_req_type;

endpackage : swd_pkg

// [rtl/swd_timer.sv]
`timescale 1ns/100ps
`include "swd_consts.svh"

// Up-counter that flags the last cycle of a window of limit cycles.
module swd_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [31:0] limit,
  // Status
  output logic [31:0] count,
  output logic expire
);

  // Expiry is the last counted cycle of the window.
  assign expire = run && !clear && (count == limit - 32'h0000_0001);

  // Clear wins, otherwise count and wrap on expiry.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
    end else if (clear || expire) begin
      count <= 32'h0000_0000;
    end else if (run) begin
      count <= count + 32'h0000_0001;
    end
  end

endmodule : swd_timer

// [rtl/swd_watchdog.sv]
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "swd_consts.svh"

// Notes on behaviour
// - External capacitance sets upper timeout, 10 pF/ms.
// - Floating timing pin gives about 2 ms.
// - Timing pin at supply gives 1.6 s.
// - Select low: initial timeout equals upper timeout.
// - Select floating 8x, at supply 64x.
// - Reset rising edge clears counter, starts initial window.
// - Missed first kick gives an ordinary fault.
// - After first kick use upper timeout.
// - Timeout drops fault flag and reset together.
// - Kick ignored while reset output is low.
// - Kick after reset release raises fault flag.
module swd_watchdog #(
  parameter int TIMEOUT_CAPACITANCE_PF = `SWD_DEF_CAP_PF,
  parameter int MIN_TIMEOUT_CYCLES = `SWD_T_MIN_US * `SWD_CLK_MHZ,
  parameter int VCC_TIMEOUT_CYCLES = `SWD_T_VCC_MS * `SWD_US_PER_MS * `SWD_CLK_MHZ,
  parameter int CAP_TIMEOUT_CYCLES =
    TIMEOUT_CAPACITANCE_PF * `SWD_US_PER_MS * `SWD_CLK_MHZ / `SWD_PF_PER_MS,
  parameter int RESET_HOLD_CYCLES = `SWD_T_RESET_HOLD_US * `SWD_CLK_MHZ
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Supervisor pins
  input wire logic WATCHDOG_KICK_INPUT,
  input wire logic [1:0] INITIAL_TIMEOUT_SELECT,
  input wire logic [1:0] TIMEOUT_CAP_PIN,
  input wire logic SUPPLY_FAULT_N,
  output logic SYSTEM_RESET_N,
  output logic WATCHDOG_FAULT_FLAG_N
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  // Two flops release the asynchronous reset in step with the clock.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // --------------------------------------------------------------------------
  // Strap decode and window length
  // --------------------------------------------------------------------------
  swd_pkg::swd_strap_type cap_sel;
  swd_pkg::swd_strap_type init_sel;
  swd_pkg::swd_phase_type phase;
  logic [31:0] upper_timeout_period;
  logic [31:0] initial_timeout_period;
  logic [31:0] wd_limit;

  assign cap_sel = swd_pkg::swd_strap_type'(TIMEOUT_CAP_PIN);
  assign init_sel = swd_pkg::swd_strap_type'(INITIAL_TIMEOUT_SELECT);

  // Upper window from the timing pin; the unused code reads as floating.
  always_comb begin
    unique case (cap_sel)
      swd_pkg::SWD_STRAP_GND: upper_timeout_period = 32'(CAP_TIMEOUT_CYCLES);
      swd_pkg::SWD_STRAP_OPEN: upper_timeout_period = 32'(MIN_TIMEOUT_CYCLES);
      swd_pkg::SWD_STRAP_VCC: upper_timeout_period = 32'(VCC_TIMEOUT_CYCLES);
      default: upper_timeout_period = 32'(MIN_TIMEOUT_CYCLES);
    endcase
  end

  // Initial window as a multiple of the upper window.
  always_comb begin
    unique case (init_sel)
      swd_pkg::SWD_STRAP_GND:
        initial_timeout_period = upper_timeout_period * `SWD_INIT_MULT_GND;
      swd_pkg::SWD_STRAP_OPEN:
        initial_timeout_period = upper_timeout_period * `SWD_INIT_MULT_OPEN;
      swd_pkg::SWD_STRAP_VCC:
        initial_timeout_period = upper_timeout_period * `SWD_INIT_MULT_VCC;
      default: initial_timeout_period = upper_timeout_period * `SWD_INIT_MULT_OPEN;
    endcase
  end

  // The initial window applies only until the first valid kick.
  assign wd_limit = (phase == swd_pkg::SWD_PH_INITIAL) ? initial_timeout_period
                                                       : upper_timeout_period;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  swd_pkg::swd_apb_req_type req;
  logic wd_enable;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] wd_count;

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign mapped = (req.addr == `SWD_OFS_CTRL) || (req.addr == `SWD_OFS_STATUS) ||
                  (req.addr == `SWD_OFS_COUNT) || (req.addr == `SWD_OFS_LIMIT);
  assign PREADY = 1'b1;
  assign PSLVERR = req.sel && req.enable && !mapped;

  // Read data selection; unmapped and reserved bits read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (req.addr)
      `SWD_OFS_CTRL: rd_mux[`SWD_CTRL_EN_BIT] = wd_enable;
      `SWD_OFS_STATUS: begin
        rd_mux[`SWD_ST_FAULT_N_BIT] = WATCHDOG_FAULT_FLAG_N;
        rd_mux[`SWD_ST_RESET_N_BIT] = SYSTEM_RESET_N;
        rd_mux[`SWD_ST_INITIAL_BIT] = (phase == swd_pkg::SWD_PH_INITIAL);
        rd_mux[`SWD_ST_CAP_LSB +: 2] = TIMEOUT_CAP_PIN;
        rd_mux[`SWD_ST_SEL_LSB +: 2] = INITIAL_TIMEOUT_SELECT;
      end
      `SWD_OFS_COUNT: rd_mux = wd_count;
      `SWD_OFS_LIMIT: rd_mux = wd_limit;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h0000_0000;
    end else if (req.sel && !req.enable && !req.write) begin
      PRDATA <= rd_mux;
    end
  end

  // Control register write in the access cycle.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wd_enable <= `SWD_CTRL_RESET;
    end else if (req.sel && req.enable && req.write && req.addr == `SWD_OFS_CTRL) begin
      wd_enable <= req.wdata[`SWD_CTRL_EN_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Kick detection
  // --------------------------------------------------------------------------
  logic kick_q;
  logic kick_valid;
  logic wd_run;
  logic wd_expire;

  // Previous kick level for edge detection.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= WATCHDOG_KICK_INPUT;
    end
  end

  // Either edge counts, but only with reset high and no timeout this cycle.
  assign kick_valid = (kick_q ^ WATCHDOG_KICK_INPUT) && SYSTEM_RESET_N && !wd_expire;

  // --------------------------------------------------------------------------
  // Watchdog window
  // --------------------------------------------------------------------------
  assign wd_run = wd_enable && SYSTEM_RESET_N && (phase != swd_pkg::SWD_PH_HOLD);

  // Window counter is held clear in reset and cleared by each kick.
  swd_timer u_wd_timer (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .clear(!wd_run || kick_valid),
    .run(wd_run),
    .limit(wd_limit),
    .count(wd_count),
    .expire(wd_expire)
  );

  // Phase: hold while reset is low, initial after its rise, normal after a kick.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase <= swd_pkg::SWD_PH_HOLD;
    end else begin
      unique case (phase)
        swd_pkg::SWD_PH_HOLD: begin
          if (SYSTEM_RESET_N) begin
            phase <= swd_pkg::SWD_PH_INITIAL;
          end
        end
        swd_pkg::SWD_PH_INITIAL, swd_pkg::SWD_PH_NORMAL: begin
          if (!SYSTEM_RESET_N || wd_expire) begin
            phase <= swd_pkg::SWD_PH_HOLD;
          end else if (kick_valid) begin
            phase <= swd_pkg::SWD_PH_NORMAL;
          end
        end
        default: phase <= swd_pkg::SWD_PH_HOLD;
      endcase
    end
  end

  // Fault flag: a timeout wins over a kick in the same cycle.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WATCHDOG_FAULT_FLAG_N <= 1'b1;
    end else if (wd_expire) begin
      WATCHDOG_FAULT_FLAG_N <= 1'b0;
    end else if (kick_valid) begin
      WATCHDOG_FAULT_FLAG_N <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // System reset output
  // --------------------------------------------------------------------------
  logic hold_clear;
  logic hold_expire;

  assign hold_clear = wd_expire || !SUPPLY_FAULT_N;

  // Reset hold time, restarted by a timeout or a supply fault.
  swd_timer u_hold_timer (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .clear(hold_clear),
    .run(!SYSTEM_RESET_N),
    .limit(32'(RESET_HOLD_CYCLES)),
    .count(),
    .expire(hold_expire)
  );

  // Reset drops with the fault flag on a timeout, alone on a supply fault, and rises after the hold time.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SYSTEM_RESET_N <= 1'b0;
    end else if (hold_clear) begin
      SYSTEM_RESET_N <= 1'b0;
    end else if (hold_expire) begin
      SYSTEM_RESET_N <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  a_cap_ext_window: assert property (
    cap_sel == swd_pkg::SWD_STRAP_GND |-> upper_timeout_period == 32'(CAP_TIMEOUT_CYCLES))
    else $error("Capacitor window not used.");
  a_cap_open_min: assert property (
    cap_sel == swd_pkg::SWD_STRAP_OPEN |-> upper_timeout_period == 32'(MIN_TIMEOUT_CYCLES))
    else $error("Floating pin window wrong.");
  a_cap_vcc_fixed: assert property (
    cap_sel == swd_pkg::SWD_STRAP_VCC |-> upper_timeout_period == 32'(VCC_TIMEOUT_CYCLES))
    else $error("Supply pin window wrong.");
  a_init_gnd_equal: assert property (
    phase == swd_pkg::SWD_PH_INITIAL && init_sel == swd_pkg::SWD_STRAP_GND
    |-> wd_limit == upper_timeout_period)
    else $error("Initial window not equal to upper.");
  a_init_open_mult: assert property (
    phase == swd_pkg::SWD_PH_INITIAL && init_sel == swd_pkg::SWD_STRAP_OPEN
    |-> wd_limit == 32'(upper_timeout_period * `SWD_INIT_MULT_OPEN))
    else $error("Initial window not eight times upper.");
  a_rise_starts_init: assert property (
    $rose(SYSTEM_RESET_N) |=> phase == swd_pkg::SWD_PH_INITIAL && wd_count == 32'h0000_0000)
    else $error("Reset rise did not start initial window.");
  a_init_expire_fault: assert property (
    wd_expire && phase == swd_pkg::SWD_PH_INITIAL
    |=> !WATCHDOG_FAULT_FLAG_N ##1 phase == swd_pkg::SWD_PH_HOLD)
    else $error("Initial timeout gave no fault.");
  a_kick_to_normal: assert property (
    kick_valid && phase == swd_pkg::SWD_PH_INITIAL |=> phase == swd_pkg::SWD_PH_NORMAL)
    else $error("First kick did not switch windows.");
  a_timeout_both_low: assert property (
    wd_expire |=> !WATCHDOG_FAULT_FLAG_N && !SYSTEM_RESET_N)
    else $error("Timeout did not drop both outputs.");
  a_kick_ignored_low: assert property (
    !SYSTEM_RESET_N |=> $stable(WATCHDOG_FAULT_FLAG_N))
    else $error("Fault flag moved while reset low.");
  a_kick_releases_flag: assert property (
    kick_valid |=> WATCHDOG_FAULT_FLAG_N && wd_count == 32'h0000_0000)
    else $error("Kick did not release fault flag.");
  a_hold_release: assert property (
    hold_expire && !hold_clear |=> SYSTEM_RESET_N)
    else $error("Reset not released after hold.");

endmodule : swd_watchdog

// [test/swd_kick_host.sv]
`timescale 1ns/100ps

// Supervised processor that toggles the kick line at a set spacing.
module swd_kick_host (
  // Clock and observed system reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench control; rude toggles even while reset is low
  input wire logic enable,
  input wire logic rude,
  input wire logic [15:0] period,
  // Kick line
  output logic kick
);
  logic [15:0] gap;
  logic level = 1'b0;

  // Toggle once every period cycles, only while out of reset unless told otherwise.
  always_ff @(posedge clk) begin
    if (!enable || (!reset_n && !rude)) begin
      gap <= 16'h0000;
    end else if (gap >= period - 16'h0001) begin
      gap <= 16'h0000;
      level <= ~level;
    end else begin
      gap <= gap + 16'h0001;
    end
  end

  // The level change itself is the kick.
  assign kick = level;
endmodule : swd_kick_host

// [test/tb_supervisor_watchdog_timer.sv]
`timescale 1ns/100ps

// Bench for the watchdog with shortened timeout counts.
module tb_supervisor_watchdog_timer;
  logic clk = 1'b0, arst_n, psel, penable, pwrite, pready, pslverr, kick, supply_n;
  logic sys_rst_n, fault_n, kick_en, rude;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] cap, sel;
  logic [15:0] period, seed;
  logic err;
  int fails = 0, compares = 0, t, lim, up;

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  swd_watchdog #(.MIN_TIMEOUT_CYCLES(20), .VCC_TIMEOUT_CYCLES(40),
    .CAP_TIMEOUT_CYCLES(30), .RESET_HOLD_CYCLES(10)) i_swd_watchdog (
    .SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .WATCHDOG_KICK_INPUT(kick), .INITIAL_TIMEOUT_SELECT(sel), .TIMEOUT_CAP_PIN(cap),
    .SUPPLY_FAULT_N(supply_n), .SYSTEM_RESET_N(sys_rst_n), .WATCHDOG_FAULT_FLAG_N(fault_n));

  swd_kick_host i_swd_kick_host (.clk(clk), .reset_n(sys_rst_n), .enable(kick_en),
    .rude(rude), .period(period), .kick(kick));

  // ---------------------------------------------------------------------------
  // Expectations and helpers
  // ---------------------------------------------------------------------------
  function automatic int upper(input logic [1:0] c);
    return (c == 2'h0) ? 30 : (c == 2'h2) ? 40 : 20;
  endfunction : upper

  function automatic int mult(input logic [1:0] s);
    return (s == 2'h0) ? 1 : (s == 2'h2) ? 64 : 8;
  endfunction : mult

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 50), 32'h1, "bus answer missing");
  endtask : apb

  // Count falling edges until the system reset shows level v, at most max.
  task automatic wait_rst(input logic v, input int max);
    t = 0;
    while (sys_rst_n !== v && t < max) begin
      @(negedge clk);
      t++;
    end
  endtask : wait_rst

  // Full reset with new strap values, then wait for the reset output to rise.
  task automatic restart(input logic [1:0] c, input logic [1:0] s);
    @(posedge clk);
    arst_n <= 1'b0;
    cap <= c;
    sel <= s;
    kick_en <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    wait_rst(1'b1, 40);
    chk(32'(sys_rst_n), 32'h1, "reset output never rose");
  endtask : restart

  task automatic wrap_up;
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Cut a hang short; the tests need well under half of this span.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t run did not finish", $time);
    wrap_up;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, cap, sel, kick_en, rude} = '0;
    supply_n = 1'b1;
    period = 16'h0004;
    seed = 16'h0017;
    // Every strap combination, the unused code too, sets the initial window length.
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 4; s++) begin
        restart(c[1:0], s[1:0]);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'(upper(c[1:0]) * mult(s[1:0])), "initial limit");
        apb(1'b0, 8'h04, 32'h0);
        chk({rd[7:4], rd[2:0]}, {s[1:0], c[1:0], 3'h7}, "status");
      end
    end
    // Disabling stops and clears the window; enabling again reads back in the control bit.
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0, "control off readback");
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0, "count while disabled");
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd & 32'h1, 32'h1, "control readback");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    // Random straps: missed first kick, ignored kicks, recovery and steady kicking.
    for (int n = 0; n < 3; n++) begin
      seed = lfsr(seed);
      up = upper(2'(seed % 3));
      lim = up * mult(2'((seed >> 4) % 3));
      restart(2'(seed % 3), 2'((seed >> 4) % 3));
      wait_rst(1'b0, lim + 5);
      chk(t, lim + 1, "initial timeout length");
      chk(32'(fault_n), 32'h0, "flag with reset");
      @(posedge clk);
      rude <= 1'b1;
      period <= 16'h0001;
      kick_en <= 1'b1;
      repeat (6) @(negedge clk);
      chk({fault_n, sys_rst_n}, 2'b00, "kick during reset");
      @(posedge clk);
      rude <= 1'b0;
      period <= 16'(2 + seed[15:8] % (up - 4));
      wait_rst(1'b1, 20);
      repeat (up) @(negedge clk);
      chk(32'(fault_n), 32'h1, "flag after kick");
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'(up), "upper limit after kick");
      wait_rst(1'b0, 4 * up);
      chk(t, 4 * up, "kicked watchdog tripped");
      @(posedge clk);
      supply_n <= 1'b0;
      repeat (3) @(negedge clk);
      chk({fault_n, sys_rst_n}, 2'b10, "supply reset flag");
      @(posedge clk);
      supply_n <= 1'b1;
    end
    wrap_up;
  end
endmodule : tb_supervisor_watchdog_timer
